// ### rtl/sfr_bank_pkg.sv
// Package with addresses, field positions, reset values and types for the SFR bank
package sfr_bank_pkg;
   // Special-function addresses inside the data memory
   localparam logic [7:0] ADDR_PORT_ZERO = 8'h00;
   localparam logic [7:0] ADDR_PTR_ZERO = 8'h01;
   localparam logic [7:0] ADDR_PORT_ONE = 8'h02;
   localparam logic [7:0] ADDR_PTR_ONE = 8'h03;
   localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
   localparam logic [7:0] ADDR_PC_LOW = 8'h06;
   localparam logic [7:0] ADDR_CTRL_A = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0A;
   localparam logic [7:0] ADDR_CTRL_B = 8'h28;
   localparam logic [7:0] SFR_TOP = 8'h3F;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // Bank select fields
   localparam int PROG_BANK_BIT = 5;
   localparam logic [7:0] BANK_SEL_MASK = 8'h23;
   // Flag fields
   localparam int DOG_BIT = 5;
   localparam int SLEEP_BIT = 4;
   localparam int WRAP_BIT = 3;
   localparam int ZERO_BIT = 2;
   localparam int NIB_BIT = 1;
   localparam int CARRY_BIT = 0;
   localparam logic [7:0] FLAGS_WR_MASK = 8'h0F;
   // Control register reset values and masks
   localparam logic [7:0] CTRL_A_RESET = 8'h01;
   localparam logic [7:0] CTRL_B_RESET = 8'h01;
   localparam logic [7:0] CTRL_B_MASK = 8'hC3;
   localparam logic [7:0] TIMER2_SEL_MASK = 8'hC0;
   localparam logic [1:0] LCD_DIV_3 = 2'h0;
   localparam logic [1:0] LCD_DIV_4 = 2'h1;
   localparam logic [3:0] DIV_THREE = 4'h3;
   localparam logic [3:0] DIV_FOUR = 4'h4;
   localparam logic [3:0] DIV_EIGHT = 4'h8;
   localparam logic [13:0] PC_RESET = 14'h0000;

   // ALU result as reported by the core
   typedef struct packed {
      logic valid;
      logic set_wrap;
      logic set_zero;
      logic set_nib;
      logic set_carry;
      logic wrap;
      logic zero;
      logic nib;
      logic carry;
   } alu_flags_t;

   // Data memory access from the instruction stream
   typedef struct packed {
      logic rd;
      logic wr;
      logic ind;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

   // Clock and system control decoded outputs
   typedef struct packed {
      logic [1:0] timer2_source_sel;
      logic slow_clock_source_sel;
      logic [3:0] lcd_divisor;
      logic sub_clock_sleep_enable;
      logic sub_clock_source_sel;
      logic slow_crystal_power_mode;
      logic [1:0] ext_irq_edge_sel;
      logic buzzer_source_sel;
      logic slow_crystal_sleep_enable;
   } sys_ctrl_t;
endpackage

// ### rtl/sfr_banking_status_ctrl.sv
// SFR block: indirect ports, bank select, status flags and system control registers
`timescale 1ns/10ps
module sfr_banking_status_ctrl (
   // Clock and resets
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SOFT_RESET,
   input wire logic DOG_RESET,
   // Core events
   input wire logic DOG_CLEAR,
   input wire logic SLEEP_EXEC,
   input wire logic DOG_TIMEOUT,
   input wire logic SLEEPING,
   input wire logic TOUCH_ENABLE,
   input wire sfr_bank_pkg::alu_flags_t ALU,
   // Data memory request from the core
   input wire sfr_bank_pkg::mem_req_t REQ,
   // Memory side
   input wire logic [7:0] RAM_RDATA,
   output logic RAM_RD,
   output logic RAM_WR,
   output logic [1:0] RAM_BANK,
   output logic [7:0] RAM_ADDR,
   output logic [7:0] RAM_WDATA,
   // Read data back to the core
   output logic [7:0] RDATA,
   output logic RDATA_VALID,
   // Program counter control
   output logic [13:0] PC_JUMP,
   output logic PC_JUMP_VALID,
   output logic DUMMY_CYCLE,
   output logic PROG_BANK,
   // System control outputs
   output sfr_bank_pkg::sys_ctrl_t SYS_CTRL
);
   import sfr_bank_pkg::*;

   logic [7:0] ptr_zero_q;
   logic [7:0] ptr_one_q;
   logic [7:0] bank_q;
   logic [7:0] flags_q;
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] pc_low_q;
   logic [7:0] eff_addr;
   logic [1:0] eff_bank;
   logic is_ind;
   logic ind_self;
   logic sfr_hit;
   logic wr_d;
   logic rd_d;
   logic [7:0] sfr_rdata;

   // True when an address is one of the two indirect ports
   function automatic logic is_port(input logic [7:0] a);
      is_port = (a == ADDR_PORT_ZERO) || (a == ADDR_PORT_ONE);
   endfunction

   // Address resolution: ports redirect through their pointers
   always_comb begin
      is_ind = is_port(REQ.addr);
      eff_addr = REQ.addr;
      eff_bank = 2'h0; // Direct access always hits bank 0
      if (REQ.addr == ADDR_PORT_ZERO) begin
         eff_addr = ptr_zero_q;
         eff_bank = 2'h0; // Pointer zero is limited to bank 0
      end else if (REQ.addr == ADDR_PORT_ONE) begin
         eff_addr = ptr_one_q;
         eff_bank = bank_q[1:0]; // Only path to banks 1 to 3
      end
      // A pointer aimed back at a port would recurse; the hardware drops it
      ind_self = is_ind && is_port(eff_addr);
      // SFRs are shared by all banks, so bank is ignored here
      sfr_hit = (eff_addr <= SFR_TOP) && !ind_self;
      wr_d = REQ.wr && !ind_self;
      rd_d = REQ.rd;
   end

   // SFR read mux; unused locations return zero
   always_comb begin
      case (eff_addr)
         ADDR_PTR_ZERO: sfr_rdata = ptr_zero_q;
         ADDR_PTR_ONE: sfr_rdata = ptr_one_q;
         ADDR_BANK_SEL: sfr_rdata = bank_q & BANK_SEL_MASK;
         ADDR_PC_LOW: sfr_rdata = pc_low_q;
         ADDR_CTRL_A: sfr_rdata = ctrl_a_q;
         ADDR_FLAGS: sfr_rdata = flags_q;
         ADDR_CTRL_B: sfr_rdata = ctrl_b_q & CTRL_B_MASK;
         default: sfr_rdata = READ_ZERO;
      endcase
   end

   // Memory pointers behave as plain registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ptr_zero_q <= 8'h00;
         ptr_one_q <= 8'h00;
      end else if (wr_d && sfr_hit) begin
         if (eff_addr == ADDR_PTR_ZERO) begin
            ptr_zero_q <= REQ.wdata;
         end
         if (eff_addr == ADDR_PTR_ONE) begin
            ptr_one_q <= REQ.wdata;
         end
      end
   end

   // Bank select; a watchdog reset while asleep keeps the data bank
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         bank_q <= 8'h00;
      end else if (SOFT_RESET || (DOG_RESET && !SLEEPING)) begin
         bank_q <= 8'h00;
      end else if (DOG_RESET) begin
         bank_q <= bank_q; // Bank survives a wake-up time-out
      end else if (wr_d && sfr_hit && eff_addr == ADDR_BANK_SEL) begin
         bank_q <= REQ.wdata & BANK_SEL_MASK;
      end
   end

   // Status flags; writes reach only the arithmetic bits
   // Nothing here pushes the flags on interrupt or call
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         flags_q <= 8'h00; // Power-up clears both system flags
      end else begin
         if (wr_d && sfr_hit && eff_addr == ADDR_FLAGS) begin
            flags_q[3:0] <= REQ.wdata[3:0] & FLAGS_WR_MASK[3:0];
         end else if (ALU.valid) begin
            if (ALU.set_wrap) begin
               flags_q[WRAP_BIT] <= ALU.wrap;
            end
            if (ALU.set_zero) begin
               flags_q[ZERO_BIT] <= ALU.zero;
            end
            if (ALU.set_nib) begin
               flags_q[NIB_BIT] <= ALU.nib;
            end
            if (ALU.set_carry) begin
               flags_q[CARRY_BIT] <= ALU.carry; // Also rotate through carry
            end
         end
         // Time-out wins over a same-cycle clear so the event is not lost
         if (DOG_TIMEOUT) begin
            flags_q[DOG_BIT] <= 1'b1;
         end else if (DOG_CLEAR || SLEEP_EXEC) begin
            flags_q[DOG_BIT] <= 1'b0;
         end
         if (SLEEP_EXEC) begin
            flags_q[SLEEP_BIT] <= 1'b1;
         end else if (DOG_CLEAR) begin
            flags_q[SLEEP_BIT] <= 1'b0;
         end
      end
   end

   // Control register A; timer 2 source locked while touch is off
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_a_q <= CTRL_A_RESET;
      end else begin
         if (wr_d && sfr_hit && eff_addr == ADDR_CTRL_A) begin
            ctrl_a_q <= REQ.wdata;
         end
         if (!TOUCH_ENABLE) begin
            ctrl_a_q[7:6] <= 2'h0;
         end
      end
   end

   // Control register B
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_b_q <= CTRL_B_RESET;
      end else if (wr_d && sfr_hit && eff_addr == ADDR_CTRL_B) begin
         ctrl_b_q <= REQ.wdata & CTRL_B_MASK;
      end
   end

   // Program counter low write: jump in page with a dummy cycle
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pc_low_q <= 8'h00;
         PC_JUMP <= PC_RESET;
         PC_JUMP_VALID <= 1'b0;
         DUMMY_CYCLE <= 1'b0;
      end else begin
         PC_JUMP_VALID <= 1'b0;
         DUMMY_CYCLE <= PC_JUMP_VALID; // Pipeline refill slot
         if (wr_d && sfr_hit && eff_addr == ADDR_PC_LOW) begin
            pc_low_q <= REQ.wdata;
            PC_JUMP <= {PC_JUMP[13:8], REQ.wdata}; // Upper bits kept
            PC_JUMP_VALID <= 1'b1;
         end
      end
   end

   // Memory side, registered one cycle after the request
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RAM_RD <= 1'b0;
         RAM_WR <= 1'b0;
         RAM_BANK <= 2'h0;
         RAM_ADDR <= 8'h00;
         RAM_WDATA <= 8'h00;
      end else begin
         RAM_RD <= rd_d && !sfr_hit && !ind_self;
         RAM_WR <= wr_d && !sfr_hit;
         RAM_BANK <= eff_bank;
         RAM_ADDR <= eff_addr;
         RAM_WDATA <= REQ.wdata;
      end
   end

   // Read answer: SFR data registered, RAM data passes one cycle later
   logic sfr_rd_q;
   logic ram_rd_q;
   logic [7:0] sfr_data_q;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sfr_rd_q <= 1'b0;
         ram_rd_q <= 1'b0;
         sfr_data_q <= 8'h00;
         RDATA <= 8'h00;
         RDATA_VALID <= 1'b0;
      end else begin
         sfr_rd_q <= rd_d && (sfr_hit || ind_self);
         ram_rd_q <= RAM_RD;
         sfr_data_q <= ind_self ? READ_ZERO : sfr_rdata;
         RDATA_VALID <= sfr_rd_q || ram_rd_q;
         RDATA <= ram_rd_q ? RAM_RDATA : sfr_data_q;
      end
   end

   // Decoded system control outputs
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PROG_BANK <= 1'b0;
         SYS_CTRL <= '0;
      end else begin
         PROG_BANK <= bank_q[PROG_BANK_BIT];
         SYS_CTRL.timer2_source_sel <= ctrl_a_q[7:6] & {2{TOUCH_ENABLE}};
         SYS_CTRL.slow_clock_source_sel <= ctrl_a_q[5];
         case (ctrl_a_q[4:3])
            LCD_DIV_3: SYS_CTRL.lcd_divisor <= DIV_THREE;
            LCD_DIV_4: SYS_CTRL.lcd_divisor <= DIV_FOUR;
            default: SYS_CTRL.lcd_divisor <= DIV_EIGHT;
         endcase
         SYS_CTRL.sub_clock_sleep_enable <= ctrl_a_q[2];
         SYS_CTRL.sub_clock_source_sel <= ctrl_a_q[1];
         SYS_CTRL.slow_crystal_power_mode <= ctrl_a_q[0];
         SYS_CTRL.ext_irq_edge_sel <= ctrl_b_q[7:6];
         SYS_CTRL.buzzer_source_sel <= ctrl_b_q[1];
         SYS_CTRL.slow_crystal_sleep_enable <= ctrl_b_q[0];
      end
   end
endmodule

// ### tb/sfr_chk.sv
// Checker for the SFR bank: answer timing and decode seen at the block ports
`timescale 1ns/10ps
module sfr_chk (
   // Clock and request
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic TOUCH_ENABLE,
   input wire sfr_bank_pkg::mem_req_t REQ,
   // Memory side
   input wire logic [7:0] RAM_RDATA,
   input wire logic RAM_RD,
   input wire logic RAM_WR,
   input wire logic [1:0] RAM_BANK,
   input wire logic [7:0] RAM_ADDR,
   input wire logic [7:0] RAM_WDATA,
   // Answers
   input wire logic [7:0] RDATA,
   input wire logic RDATA_VALID,
   input wire logic [13:0] PC_JUMP,
   input wire logic PC_JUMP_VALID,
   input wire logic DUMMY_CYCLE,
   input wire sfr_bank_pkg::sys_ctrl_t SYS_CTRL
);
   import sfr_bank_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // Jumps only replace the low byte; the page bits must not move
   a_pc_low_jump: assert property (REQ.wr && REQ.addr == ADDR_PC_LOW
      |=> PC_JUMP_VALID && PC_JUMP[7:0] == $past(REQ.wdata)) else $error("no jump");
   a_jump_dummy: assert property (PC_JUMP_VALID |=> DUMMY_CYCLE)
      else $error("no dummy");
   a_jump_page: assert property (PC_JUMP_VALID |-> $stable(PC_JUMP[13:8]))
      else $error("page changed");
   // Direct addressing ignores the bank select
   a_direct_read: assert property (REQ.rd && REQ.addr > SFR_TOP
      |=> RAM_RD && RAM_BANK == 2'h0 && RAM_ADDR == $past(REQ.addr)) else $error("direct rd");
   a_direct_write: assert property (REQ.wr && REQ.addr > SFR_TOP
      |=> RAM_WR && RAM_BANK == 2'h0 && RAM_WDATA == $past(REQ.wdata)) else $error("direct wr");
   a_ram_return: assert property (RAM_RD
      |-> ##2 RDATA_VALID && RDATA == $past(RAM_RDATA)) else $error("memory data lost");
   a_unused_zero: assert property (REQ.rd && REQ.addr > ADDR_CTRL_B
      && REQ.addr <= SFR_TOP |-> ##2 RDATA_VALID && RDATA == READ_ZERO)
      else $error("unused not zero");
   a_port_zero_bank: assert property (REQ.rd && REQ.addr == ADDR_PORT_ZERO ##1 RAM_RD
      |-> RAM_BANK == 2'h0) else $error("port zero left bank 0");
   // Register path may lag, so the touch line must be low a few cycles first
   a_touch_off: assert property (!TOUCH_ENABLE [*3]
      |-> SYS_CTRL.timer2_source_sel == 2'h0) else $error("timer2 source not forced");

   // Main scenarios reached
   c_jump: cover property (PC_JUMP_VALID);
   c_bank3: cover property (RAM_WR && RAM_BANK == 2'h3);
   c_ram_read: cover property (RAM_RD ##2 RDATA_VALID);
endmodule

bind sfr_banking_status_ctrl sfr_chk chk (.CLK, .RST_N, .TOUCH_ENABLE, .REQ, .RAM_RDATA,
   .RAM_RD, .RAM_WR, .RAM_BANK, .RAM_ADDR, .RAM_WDATA, .RDATA, .RDATA_VALID, .PC_JUMP,
   .PC_JUMP_VALID, .DUMMY_CYCLE, .SYS_CTRL);

// ### tb/sfr_banking_status_ctrl_tb.sv
// Self-checking bench for the SFR bank with a small data memory model
`timescale 1ns/10ps
module sfr_banking_status_ctrl_tb;
   import sfr_bank_pkg::*;
   localparam int SOFT = 0, DOGR = 1, CLR = 2, SLP = 3, TMO = 4;
   logic clk, rst_n, sleeping, touch, hold, ram_rd, ram_wr, rdv, pcv, dummy, pbank;
   logic [4:0] ev;
   logic [1:0] ram_bank;
   logic [3:0] m, r;
   logic [7:0] ram_rdata, ram_addr, ram_wdata, rdata, d, f;
   logic [7:0] v [4];
   logic [7:0] mem [1024];
   logic [13:0] pc;
   alu_flags_t alu;
   mem_req_t req;
   sys_ctrl_t sc;
   int fail_count, num_checks;

   sfr_banking_status_ctrl uut (.CLK(clk), .RST_N(rst_n), .SOFT_RESET(ev[SOFT]),
      .DOG_RESET(ev[DOGR]), .DOG_CLEAR(ev[CLR]), .SLEEP_EXEC(ev[SLP]), .DOG_TIMEOUT(ev[TMO]),
      .SLEEPING(sleeping), .TOUCH_ENABLE(touch), .ALU(alu), .REQ(req), .RAM_RDATA(ram_rdata),
      .RAM_RD(ram_rd), .RAM_WR(ram_wr), .RAM_BANK(ram_bank), .RAM_ADDR(ram_addr),
      .RAM_WDATA(ram_wdata), .RDATA(rdata), .RDATA_VALID(rdv), .PC_JUMP(pc),
      .PC_JUMP_VALID(pcv), .DUMMY_CYCLE(dummy), .PROG_BANK(pbank), .SYS_CTRL(sc));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Memory answers one cycle late; idle data toggles so a late sample shows up
   always @(negedge clk) begin
      if (ram_wr) mem[{ram_bank, ram_addr}] <= ram_wdata;
      if (ram_rd) ram_rdata <= mem[{ram_bank, ram_addr}];
      else if (!hold) ram_rdata <= ~ram_rdata;
      hold <= ram_rd;
   end

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Request fields are rd, wr, ind, addr, wdata
   task automatic wr(logic [7:0] a, logic [7:0] dat);
      req = {3'b010, a, dat};
      @(negedge clk) req = '0;
      repeat (3) @(negedge clk);
   endtask

   task automatic rd(string what, logic [7:0] a, logic [7:0] exp);
      int n;
      req = {3'b100, a, 8'h00};
      @(negedge clk) req = '0;
      n = 0;
      while (rdv !== 1'b1 && n < 6) begin
         @(negedge clk);
         n++;
      end
      check(what, rdv === 1'b1 ? rdata : 8'hXX, exp);
      repeat (2) @(negedge clk);
   endtask

   task automatic pulse(int k);
      ev[k] = 1'b1;
      @(negedge clk) ev[k] = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   function automatic logic [7:0] ctl_a(logic [7:0] x, logic t);
      return t ? x : x & ~TIMER2_SEL_MASK;
   endfunction

   function automatic logic [7:0] lcd_div(logic [1:0] sel);
      return sel == LCD_DIV_3 ? 8'h03 : sel == LCD_DIV_4 ? 8'h04 : 8'h08;
   endfunction

   function automatic logic [7:0] seen_a(sys_ctrl_t s);
      return {s.timer2_source_sel, s.slow_clock_source_sel, 2'h0, s.sub_clock_sleep_enable,
         s.sub_clock_source_sel, s.slow_crystal_power_mode};
   endfunction

   task automatic wrap_up();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {rst_n, ev, sleeping, touch, hold, alu, req} = '0;
      ram_rdata = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
      void'($urandom(90246));
      repeat (16) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      @(negedge clk);
      f = {6'h0, sc.slow_crystal_power_mode, sc.slow_crystal_sleep_enable};
      check("reset out", f, 8'h03);
      check("reset lcd", {4'h0, sc.lcd_divisor}, 8'h03);
      rd("ctrl_a reset", ADDR_CTRL_A, CTRL_A_RESET);
      rd("ctrl_b reset", ADDR_CTRL_B, CTRL_B_RESET);
      rd("flags reset", ADDR_FLAGS, 8'h00);
      // Touch off on even passes; edge codes cycle through all four
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom());
         touch = i[0];
         wr(ADDR_CTRL_A, d);
         rd("ctrl_a", ADDR_CTRL_A, ctl_a(d, touch));
         check("ctrl_a out", seen_a(sc), ctl_a(d, touch) & 8'hE7);
         check("lcd div", {4'h0, sc.lcd_divisor}, lcd_div(d[4:3]));
         d = {2'(i), 6'($urandom())};
         wr(ADDR_CTRL_B, d);
         rd("ctrl_b", ADDR_CTRL_B, d & CTRL_B_MASK);
         check("ctrl_b out", {4'h0, sc[3:0]}, {4'h0, d[7:6], d[1:0]});
      end
      repeat (3) rd("unused", 8'h29 + 8'($urandom_range(22)), READ_ZERO);
      rd("unused top", SFR_TOP, READ_ZERO);
      wr(ADDR_BANK_SEL, 8'hFF);
      rd("bank sel", ADDR_BANK_SEL, BANK_SEL_MASK);
      check("prog bank", {7'h0, pbank}, 8'h01);
      // Same offset in every bank, filled through pointer one
      for (int b = 0; b < 4; b++) begin
         v[b] = 8'($urandom());
         wr(ADDR_BANK_SEL, 8'(b));
         wr(ADDR_PTR_ONE, 8'h50);
         wr(ADDR_PORT_ONE, v[b]);
      end
      check("prog bank", {7'h0, pbank}, 8'h00);
      wr(ADDR_PTR_ZERO, 8'h50);
      v[0] = 8'hA5;
      wr(ADDR_PORT_ZERO, v[0]);
      wr(8'h51, 8'h5A);
      check("direct write", mem[{2'h0, 8'h51}], 8'h5A);
      rd("sfr in bank 3", ADDR_PTR_ONE, 8'h50);
      rd("direct read", 8'h50, v[0]);
      rd("port zero", ADDR_PORT_ZERO, v[0]);
      for (int b = 0; b < 4; b++) begin
         wr(ADDR_BANK_SEL, 8'(b));
         rd("port one", ADDR_PORT_ONE, v[b]);
      end
      // Pointers aimed at the ports themselves
      wr(ADDR_PTR_ONE, ADDR_PORT_ZERO);
      rd("self port", ADDR_PORT_ONE, READ_ZERO);
      wr(ADDR_PORT_ONE, 8'h77);
      rd("ptr zero kept", ADDR_PTR_ZERO, 8'h50);
      wr(ADDR_PTR_ZERO, ADDR_PORT_ONE);
      rd("self port", ADDR_PORT_ZERO, READ_ZERO);
      sleeping = 1'b1;
      pulse(DOGR);
      rd("bank sleep dog", ADDR_BANK_SEL, 8'h03);
      sleeping = 1'b0;
      pulse(DOGR);
      rd("bank dog", ADDR_BANK_SEL, 8'h00);
      wr(ADDR_BANK_SEL, 8'h02);
      pulse(SOFT);
      rd("bank soft", ADDR_BANK_SEL, 8'h00);
      wr(ADDR_FLAGS, 8'hFF);
      rd("flags write", ADDR_FLAGS, FLAGS_WR_MASK);
      pulse(TMO);
      rd("flags timeout", ADDR_FLAGS, 8'h2F);
      pulse(SLP);
      rd("flags sleep", ADDR_FLAGS, 8'h1F);
      pulse(TMO);
      wr(ADDR_FLAGS, 8'h00);
      rd("flags kept", ADDR_FLAGS, 8'h30);
      // Power-up reset in mid-run must clear both system flags while they are set
      rst_n = 1'b0;
      @(negedge clk) rst_n = 1'b1;
      @(negedge clk);
      rd("flags power-up", ADDR_FLAGS, 8'h00);
      pulse(SLP);
      pulse(TMO);
      rd("flags events", ADDR_FLAGS, 8'h30);
      pulse(CLR);
      rd("flags clear", ADDR_FLAGS, 8'h00);
      // Only the flags whose update enable is set may move
      f = 8'h00;
      for (int i = 0; i < 6; i++) begin
         m = 4'($urandom());
         r = 4'($urandom());
         alu = {1'b1, m, r};
         @(negedge clk) alu = '0;
         f[3:0] = (f[3:0] & ~m) | (r & m);
         rd("alu flags", ADDR_FLAGS, f);
      end
      d = 8'($urandom());
      req = {3'b010, ADDR_PC_LOW, d};
      @(negedge clk) req = '0;
      check("jump", pcv === 1'b1 ? pc[7:0] : 8'hXX, d);
      @(negedge clk);
      check("dummy", {7'h0, dummy}, 8'h01);
      wrap_up();
   end

   // Hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #150000;
      fail_count++;
      wrap_up();
   end
endmodule
